// *** verilog/can_fifo_interrupt_and_netfilter.sv ***
// Register front end, module enable handshake and net filter of the CAN block.
`timescale 1ns/1ps
// Operation
// - The filter count sets how many payload bits meet identifier bits.
// - Count codes above 18 are invalid and never give a filter match.
// - A disable lets a frame in progress finish; busy holds until off.
// - There are 32 independent FIFO interrupt registers, numbered 0 to 31.
// - Bits 26 to 24 enable transmit room, half and drained; reset zero.
// - Bits 19 to 16 enable receive overrun, full, half, pending; reset 0.
// - Flags in bits 10 to 8 and 2 to 0 are read-only live FIFO state.
// - The transmit room flag reads zero while the FIFO receives.
// - Bits 31 to 27, 23 to 20 and 15 to 11 of a FIFO register read 0.
// - Busy reads one while active and zero only once fully disabled.
module can_fifo_interrupt_and_netfilter #(
   parameter int FIFO_COUNT = 32
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   input  wire logic [FIFO_COUNT-1:0] fifo_direction_transmit,
   input  wire logic [FIFO_COUNT-1:0] fifo_full,
   input  wire logic [FIFO_COUNT-1:0] fifo_half,
   input  wire logic [FIFO_COUNT-1:0] fifo_empty,
   input  wire logic [FIFO_COUNT-1:0] rx_frame_arrive,
   input  wire logic                  frame_in_progress,
   input  wire logic [23:0]           rx_payload,
   input  wire logic [17:0]           acceptance_filter_value,
   output logic                       module_enable,
   output logic                       module_active_flag,
   output logic                       net_filter_match,
   output logic [FIFO_COUNT-1:0]      fifo_irq,
   output logic                       irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Refused at elaboration: the slot index is only five bits wide.
   if (FIFO_COUNT < 1 || FIFO_COUNT > can_fifo_irq_pkg::FIFO_MAX) begin
      $error("FIFO_COUNT must lie between 1 and 32");
   end

   logic                        ctrl_en_reg;
   logic                        ctrl_en_next;
   logic [4:0]                  net_filter_bit_count_reg;
   logic [4:0]                  net_filter_bit_count_next;
   can_fifo_irq_pkg::mod_state_t state_reg;
   can_fifo_irq_pkg::mod_state_t state_next;
   logic [3:0]                  settle_cnt_reg;
   logic [3:0]                  settle_cnt_next;
   logic                        module_enable_reg;
   logic                        module_active_flag_reg;
   logic                        disable_done;
   logic [2:0]                  irq_stat_reg;
   logic [2:0]                  irq_stat_next;
   logic [2:0]                  irq_mask_reg;
   logic [2:0]                  irq_mask_next;
   logic [2:0]                  events;
   logic                        irq_reg;
   logic                        net_filter_match_reg;
   logic                        net_filter_match_next;
   logic                        count_bad;
   logic [31:0]                 reg_rdata_reg;
   logic [31:0]                 reg_rdata_next;
   logic [4:0]                  fifo_idx;
   logic                        fifo_hit;
   logic                        ctrl_hit;
   logic [31:0]                 slot_rdata [FIFO_COUNT];
   logic [FIFO_COUNT-1:0]       slot_irq;
   logic [FIFO_COUNT-1:0]       fifo_irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode. Unaligned or unmapped addresses read zero and ignore
   // writes.
   assign fifo_idx = 5'((reg_addr - can_fifo_irq_pkg::FIFO_BASE_OFFSET)
                        >> can_fifo_irq_pkg::FIFO_IDX_SHIFT);
   assign fifo_hit = (reg_addr >= can_fifo_irq_pkg::FIFO_BASE_OFFSET) &&
                     (reg_addr[1:0] == 2'h0) &&
                     (int'(fifo_idx) < FIFO_COUNT);
   assign ctrl_hit = (reg_addr == can_fifo_irq_pkg::CTRL_OFFSET);

   ////////////////////////////////////////////////////////////////////////////
   // Per-FIFO slots, one independent register each.
   genvar g;
   generate
      for (g = 0; g < FIFO_COUNT; g++) begin : gen_slot
         fifo_slot_if slot_bus ();
         assign slot_bus.wr           = reg_wr && fifo_hit &&
                                        (fifo_idx == 5'(g));
         assign slot_bus.wdata        = reg_wdata;
         assign slot_bus.tx_mode      = fifo_direction_transmit[g];
         assign slot_bus.full         = fifo_full[g];
         assign slot_bus.half         = fifo_half[g];
         assign slot_bus.empty        = fifo_empty[g];
         assign slot_bus.frame_arrive = rx_frame_arrive[g];
         assign slot_rdata[g]         = slot_bus.rdata;
         assign slot_irq[g]           = slot_bus.irq;
         fifo_irq_slot u_slot (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .bus     (slot_bus)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control register and enable/disable handshake.
   always_comb begin
      ctrl_en_next              = ctrl_en_reg;
      net_filter_bit_count_next = net_filter_bit_count_reg;
      if (reg_wr && ctrl_hit) begin
         ctrl_en_next              =
            reg_wdata[can_fifo_irq_pkg::CTRL_ENABLE_BIT];
         net_filter_bit_count_next = reg_wdata[4:0];
      end
   end

   // The engine keeps frame_in_progress high until its frame is done, so a
   // disable never cuts a frame in half.
   always_comb begin
      state_next      = state_reg;
      settle_cnt_next = settle_cnt_reg;
      unique case (state_reg)
         can_fifo_irq_pkg::MOD_OFF: begin
            if (ctrl_en_reg) begin
               state_next = can_fifo_irq_pkg::MOD_ACTIVE;
            end
         end
         can_fifo_irq_pkg::MOD_ACTIVE: begin
            if (!ctrl_en_reg) begin
               state_next = can_fifo_irq_pkg::MOD_DRAIN;
            end
         end
         can_fifo_irq_pkg::MOD_DRAIN: begin
            if (!frame_in_progress) begin
               state_next      = can_fifo_irq_pkg::MOD_SETTLE;
               settle_cnt_next = can_fifo_irq_pkg::SETTLE_CYCLES - 4'h1;
            end
         end
         can_fifo_irq_pkg::MOD_SETTLE: begin
            if (settle_cnt_reg == 4'h0) begin
               state_next = ctrl_en_reg ? can_fifo_irq_pkg::MOD_ACTIVE
                                        : can_fifo_irq_pkg::MOD_OFF;
            end else begin
               settle_cnt_next = settle_cnt_reg - 4'h1;
            end
         end
      endcase
   end

   assign disable_done = (state_reg == can_fifo_irq_pkg::MOD_SETTLE) &&
                         (settle_cnt_reg == 4'h0) && !ctrl_en_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_en_reg              <= 1'b0;
         net_filter_bit_count_reg <= can_fifo_irq_pkg::CNT_RESET;
         state_reg                <= can_fifo_irq_pkg::MOD_OFF;
         settle_cnt_reg           <= 4'h0;
         module_enable_reg        <= 1'b0;
         module_active_flag_reg   <= 1'b0;
      end else begin
         ctrl_en_reg              <= ctrl_en_next;
         net_filter_bit_count_reg <= net_filter_bit_count_next;
         state_reg                <= state_next;
         settle_cnt_reg           <= settle_cnt_next;
         module_enable_reg        <= (state_next ==
                                      can_fifo_irq_pkg::MOD_ACTIVE);
         module_active_flag_reg   <= (state_next !=
                                      can_fifo_irq_pkg::MOD_OFF);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Net filter: payload bit k (byte 0 bit 7 first) meets identifier bit k.
   assign count_bad = (net_filter_bit_count_reg > can_fifo_irq_pkg::CNT_MAX);

   always_comb begin
      logic miss;
      miss = 1'b0;
      for (int k = 0; k < can_fifo_irq_pkg::EID_W; k++) begin
         if ((5'(k) < net_filter_bit_count_reg) &&
             (rx_payload[23-k] != acceptance_filter_value[k])) begin
            miss = 1'b1;
         end
      end
      // Bad codes match nothing rather than an arbitrary subset.
      net_filter_match_next = !miss && !count_bad;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         net_filter_match_reg <= 1'b0;
      end else begin
         net_filter_match_reg <= net_filter_match_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block interrupt: sticky events, write one to clear, set beats clear.
   always_comb begin
      events = 3'h0;
      events[can_fifo_irq_pkg::EV_OVERRUN]  =
         |(rx_frame_arrive & fifo_full);
      events[can_fifo_irq_pkg::EV_DISABLED] = disable_done;
      events[can_fifo_irq_pkg::EV_BAD_CNT]  = reg_wr && ctrl_hit &&
                                              (reg_wdata[4:0] >
                                               can_fifo_irq_pkg::CNT_MAX);
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (reg_wr && reg_addr == can_fifo_irq_pkg::IRQ_STAT_OFFSET) begin
         irq_stat_next = irq_stat_reg & ~reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == can_fifo_irq_pkg::IRQ_MASK_OFFSET) begin
         irq_mask_next = reg_wdata[2:0];
      end
      irq_stat_next = irq_stat_next | events;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= can_fifo_irq_pkg::EV_RESET;
         irq_mask_reg <= can_fifo_irq_pkg::EV_RESET;
         irq_reg      <= 1'b0;
         fifo_irq_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg      <= |(irq_stat_next & irq_mask_next);
         fifo_irq_reg <= slot_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: data appear in the cycle after the strobe and only then.
   always_comb begin
      reg_rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         if (ctrl_hit) begin
            reg_rdata_next[can_fifo_irq_pkg::CTRL_ENABLE_BIT]  = ctrl_en_reg;
            reg_rdata_next[can_fifo_irq_pkg::CTRL_BUSY_BIT]    =
               module_active_flag_reg;
            reg_rdata_next[can_fifo_irq_pkg::CTRL_BAD_CNT_BIT] = count_bad;
            reg_rdata_next[4:0] = net_filter_bit_count_reg;
         end else if (reg_addr == can_fifo_irq_pkg::IRQ_STAT_OFFSET) begin
            reg_rdata_next[2:0] = irq_stat_reg;
         end else if (reg_addr == can_fifo_irq_pkg::IRQ_MASK_OFFSET) begin
            reg_rdata_next[2:0] = irq_mask_reg;
         end else if (fifo_hit) begin
            reg_rdata_next = slot_rdata[fifo_idx] &
                             can_fifo_irq_pkg::FIFO_USED_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_reg <= 32'h0000_0000;
      end else begin
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   assign reg_rdata          = reg_rdata_reg;
   assign module_enable      = module_enable_reg;
   assign module_active_flag = module_active_flag_reg;
   assign net_filter_match   = net_filter_match_reg;
   assign fifo_irq           = fifo_irq_reg;
   assign irq                = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_drain_done;
      state_reg == can_fifo_irq_pkg::MOD_DRAIN && !frame_in_progress;
   endsequence

   sequence s_settle_busy;
      module_active_flag_reg [*3];
   endsequence

   AST_DISABLE_SETTLE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      s_drain_done |=> s_settle_busy ##1
                       (!module_active_flag_reg || ctrl_en_reg))
      else $error("Busy did not fall three cycles after the frame ended");

   AST_BUSY_IN_FRAME: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (state_reg == can_fifo_irq_pkg::MOD_DRAIN) && frame_in_progress
      |=> module_active_flag_reg && !module_enable_reg)
      else $error("Module stopped in the middle of a frame");

   AST_IDLE_MEANS_OFF: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !module_active_flag_reg |-> !module_enable_reg &&
                                  (state_reg == can_fifo_irq_pkg::MOD_OFF))
      else $error("Busy low while the module is still active");

   AST_ENABLE_WAKES: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $rose(ctrl_en_reg) && state_reg == can_fifo_irq_pkg::MOD_OFF
      |=> module_active_flag_reg && module_enable_reg)
      else $error("Module did not start one cycle after enable");

   AST_NO_COMPARE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      rst_b && net_filter_bit_count_reg == 5'h00 |=> net_filter_match_reg)
      else $error("Zero filter count must always match");

   AST_FULL_COMPARE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      net_filter_bit_count_reg == 5'h12 &&
      rx_payload[6] != acceptance_filter_value[17] |=> !net_filter_match_reg)
      else $error("Eighteenth filter bit was not compared");

   AST_BAD_COUNT: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      net_filter_bit_count_reg > 5'h12 |=> !net_filter_match_reg)
      else $error("Invalid filter count produced a match");

   AST_FIFO_RESERVED: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd && fifo_hit |=> (reg_rdata & 32'hF8F0_F8F0) == 32'h0000_0000)
      else $error("Unimplemented FIFO register bits read nonzero");

   AST_READ_ONE_CYCLE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("Read data present without a read strobe");

   AST_BUSY_READ: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd && ctrl_hit |=> reg_rdata[11] == $past(module_active_flag_reg))
      else $error("Busy bit read back differs from the busy output");

   AST_BAD_FLAG_READ: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd && ctrl_hit |=>
         reg_rdata[5] == ($past(net_filter_bit_count_reg) > 5'h12))
      else $error("Invalid count flag read back wrong");

   AST_OVERRUN_STATUS: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      |(rx_frame_arrive & fifo_full) |=> irq_stat_reg[0])
      else $error("Overrun event did not set the block status bit");
endmodule

// *** verilog/can_fifo_irq_pkg.sv ***
// Shared constants and types for the CAN FIFO interrupt and net filter block.
package can_fifo_irq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int         ADDR_W            = 8;
   localparam int         DATA_W            = 32;
   localparam int         FIFO_MAX          = 32;
   localparam logic [7:0] CTRL_OFFSET       = 8'h00;
   localparam logic [7:0] IRQ_STAT_OFFSET   = 8'h04;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h08;
   localparam logic [7:0] FIFO_BASE_OFFSET  = 8'h80;
   localparam int         FIFO_IDX_SHIFT    = 2;

   ////////////////////////////////////////////////////////////////////////////
   localparam int         CTRL_ENABLE_BIT   = 15;
   localparam int         CTRL_BUSY_BIT     = 11;
   localparam int         CTRL_BAD_CNT_BIT  = 5;
   localparam int         CNT_W             = 5;
   localparam logic [4:0] CNT_MAX           = 5'h12;
   localparam logic [4:0] CNT_RESET         = 5'h00;
   localparam int         EID_W             = 18;
   localparam int         PAYLOAD_W         = 24;

   ////////////////////////////////////////////////////////////////////////////
   localparam int         TX_EN_MSB         = 26;
   localparam int         TX_EN_LSB         = 24;
   localparam int         RX_EN_MSB         = 19;
   localparam int         RX_EN_LSB         = 16;
   localparam int         RX_OVR_FLAG_BIT   = 3;
   localparam logic [2:0] TX_EN_RESET       = 3'h0;
   localparam logic [3:0] RX_EN_RESET       = 4'h0;
   localparam logic [31:0] FIFO_USED_MASK   = 32'h070F_070F;

   ////////////////////////////////////////////////////////////////////////////
   localparam int         EV_W              = 3;
   localparam int         EV_OVERRUN        = 0;
   localparam int         EV_DISABLED       = 1;
   localparam int         EV_BAD_CNT        = 2;
   localparam logic [2:0] EV_RESET          = 3'h0;
   localparam logic [3:0] SETTLE_CYCLES     = 4'h3;

   typedef enum logic [1:0] {
      MOD_OFF,
      MOD_ACTIVE,
      MOD_DRAIN,
      MOD_SETTLE
   } mod_state_t;

endpackage

// *** verilog/fifo_slot_if.sv ***
// Connection between the register front end and one FIFO interrupt slot.
`timescale 1ns/1ps
interface fifo_slot_if;
   logic        wr;
   logic [31:0] wdata;
   logic        tx_mode;
   logic        full;
   logic        half;
   logic        empty;
   logic        frame_arrive;
   logic [31:0] rdata;
   logic        irq;

   modport front (output wr, wdata, tx_mode, full, half, empty, frame_arrive,
                  input  rdata, irq);
   modport slot  (input  wr, wdata, tx_mode, full, half, empty, frame_arrive,
                  output rdata, irq);
endinterface

// *** verilog/fifo_irq_slot.sv ***
// Interrupt enables, live flags and overrun flag of one message FIFO.
`timescale 1ns/1ps
module fifo_irq_slot (
   input wire logic  clk_sys,
   input wire logic  rst_b,
   fifo_slot_if.slot bus
);
   logic [2:0] tx_en_reg;
   logic [2:0] tx_en_next;
   logic [3:0] rx_en_reg;
   logic [3:0] rx_en_next;
   logic [2:0] tx_flag_reg;
   logic [2:0] tx_flag_next;
   logic [2:0] rx_flag_reg;
   logic [2:0] rx_flag_next;
   logic       rx_overrun_flag_reg;
   logic       rx_overrun_flag_next;
   logic       irq_reg;
   logic       irq_next;
   logic       overrun_event;

   assign overrun_event = bus.frame_arrive & bus.full;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      tx_en_next           = tx_en_reg;
      rx_en_next           = rx_en_reg;
      rx_overrun_flag_next = rx_overrun_flag_reg;
      if (bus.wr) begin
         tx_en_next = bus.wdata[can_fifo_irq_pkg::TX_EN_MSB:
                                can_fifo_irq_pkg::TX_EN_LSB];
         rx_en_next = bus.wdata[can_fifo_irq_pkg::RX_EN_MSB:
                                can_fifo_irq_pkg::RX_EN_LSB];
         if (!bus.wdata[can_fifo_irq_pkg::RX_OVR_FLAG_BIT]) begin
            rx_overrun_flag_next = 1'b0;
         end
      end
      // A frame landing in the clearing cycle must not be lost.
      if (overrun_event) begin
         rx_overrun_flag_next = 1'b1;
      end
      // Order {room, half, drained}; room means nothing while receiving.
      tx_flag_next = {bus.tx_mode & ~bus.full, bus.half, bus.empty};
      rx_flag_next = {bus.full, bus.half, ~bus.empty};
      irq_next = (|(tx_flag_next & tx_en_next)) |
                 (|({rx_overrun_flag_next, rx_flag_next} & rx_en_next));
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_en_reg           <= can_fifo_irq_pkg::TX_EN_RESET;
         rx_en_reg           <= can_fifo_irq_pkg::RX_EN_RESET;
         tx_flag_reg         <= 3'h0;
         rx_flag_reg         <= 3'h0;
         rx_overrun_flag_reg <= 1'b0;
         irq_reg             <= 1'b0;
      end else begin
         tx_en_reg           <= tx_en_next;
         rx_en_reg           <= rx_en_next;
         tx_flag_reg         <= tx_flag_next;
         rx_flag_reg         <= rx_flag_next;
         rx_overrun_flag_reg <= rx_overrun_flag_next;
         irq_reg             <= irq_next;
      end
   end

   // Enables sit 16 bits above their flags, which the checks below use.
   assign bus.rdata = {5'h00, tx_en_reg, 4'h0, rx_en_reg,
                       5'h00, tx_flag_reg, 4'h0, rx_overrun_flag_reg,
                       rx_flag_reg};
   assign bus.irq   = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   AST_ENABLE_STORE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bus.wr |=> (bus.rdata[26:24] == $past(bus.wdata[26:24])) &&
                 (bus.rdata[19:16] == $past(bus.wdata[19:16])))
      else $error("FIFO enable bits did not take the written value");

   AST_FLAG_TRACK: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      rst_b |=> (bus.rdata[2] == $past(bus.full)) &&
                (bus.rdata[0] == !$past(bus.empty)) &&
                (bus.rdata[8] == $past(bus.empty)))
      else $error("FIFO status flags do not follow occupancy");

   AST_ROOM_RX_ZERO: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !bus.tx_mode |=> !bus.rdata[10])
      else $error("Transmit room flag set while FIFO receives");

   sequence s_overrun;
      bus.frame_arrive && bus.full;
   endsequence

   AST_OVERRUN_SET: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      s_overrun |=> bus.rdata[3])
      else $error("Overrun flag not set by frame into full FIFO");

   AST_OVERRUN_HOLD: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bus.rdata[3] && !(bus.wr && !bus.wdata[3]) |=> bus.rdata[3])
      else $error("Overrun flag dropped without a software clear");

   AST_IRQ_MATCH: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bus.irq == (|(bus.rdata[31:16] & bus.rdata[15:0])))
      else $error("FIFO interrupt disagrees with flags and enables");
endmodule

// *** testbench/can_engine_model.sv ***
// Behavioural bus engine: runs one received frame and pulses its arrival.
`timescale 1ns/1ps
module can_engine_model (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic module_enable,
   input  wire logic start,
   output logic      frame_in_progress,
   output logic      arrive
);
   logic [3:0] left_reg;

   // A frame only begins while the module is enabled, like a real engine.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         left_reg <= 4'h0;
         arrive   <= 1'b0;
      end else begin
         arrive <= (left_reg == 4'h1);
         if (start && module_enable && left_reg == 4'h0) begin
            left_reg <= 4'hC;
         end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
         end
      end
   end
   assign frame_in_progress = (left_reg != 4'h0);
endmodule

// *** testbench/test_can_fifo_interrupt_and_netfilter.sv ***
// Register level tests of the CAN FIFO interrupt and net filter block.
`timescale 1ns/1ps
module test_can_fifo_interrupt_and_netfilter;
   logic clk_sys, rst_b, reg_wr, reg_rd, start, me, busy, nfm, irq, fip, arr;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv, dir, full, half, empty, firq;
   logic [23:0] payload;
   logic [17:0] acc;
   int fail_count = 0;
   int total_checks = 0;
   int cnts[7] = '{0, 1, 5, 6, 18, 19, 31};

   can_fifo_interrupt_and_netfilter can_fifo_interrupt_and_netfilter_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fifo_direction_transmit(dir),
      .fifo_full(full), .fifo_half(half), .fifo_empty(empty),
      .rx_frame_arrive({31'h0, arr}), .frame_in_progress(fip),
      .rx_payload(payload), .acceptance_filter_value(acc),
      .module_enable(me), .module_active_flag(busy),
      .net_filter_match(nfm), .fifo_irq(firq), .irq(irq));
   can_engine_model can_engine_model_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .module_enable(me),
      .start(start), .frame_in_progress(fip), .arrive(arr));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      rv = reg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #200000 fail_count++;
      results;
   end
   initial begin
      {rst_b, reg_wr, reg_rd, start, reg_addr, reg_wdata} = '0;
      {dir, full, half} = '0;
      empty = 32'hFFFF_FFFE;
      payload = 24'h04_0000;
      acc = 18'h0_0000;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(8'h80); chk(rv, 32'h0000_0001);
      wr(8'hFC, 32'hFFFF_FFFF);
      rd(8'hFC); chk(rv, 32'h070F_0100);
      dir[31] <= 1'b1;
      rd(8'hFC); chk(rv, 32'h070F_0500);
      full[31] <= 1'b1;
      rd(8'hFC); chk(rv, 32'h070F_0104);
      rd(8'h40); chk(rv, 32'h0);
      $display("test register map done");
      full[0] <= 1'b1;
      wr(8'h80, 32'h0008_0000);
      wr(8'h00, 32'h0000_8000);
      start <= 1'b1;
      wr(8'h00, 32'h0000_0000);
      start <= 1'b0;
      rd(8'h00); chk(rv, 32'h0000_0800);
      chk({30'h0, me, busy}, 32'h0000_0001);
      for (int i = 0; i < 50 && rv[11]; i++) rd(8'h00);
      chk(rv, 32'h0);
      chk({31'h0, fip}, 32'h0);
      rd(8'h80); chk(rv, 32'h0008_000D);
      chk(firq, 32'h8000_0001);
      wr(8'h08, 32'h0000_0003);
      rd(8'h04); chk(rv, 32'h0000_0003);
      chk({31'h0, irq}, 32'h1);
      wr(8'h04, 32'h0000_0003);
      wr(8'h80, 32'h0008_0000);
      rd(8'h80); chk(rv, 32'h0008_0005);
      chk({31'h0, irq}, 32'h0);
      chk(firq, 32'h8000_0000);
      $display("test disable and overrun done");
      foreach (cnts[i]) begin
         wr(8'h00, 32'(cnts[i]));
         repeat (3) @(posedge clk_sys);
         chk({31'h0, nfm}, 32'(cnts[i] <= 5));
         rd(8'h00);
         chk(rv, 32'(cnts[i]) | (cnts[i] > 18 ? 32'h20 : 32'h0));
      end
      rd(8'h04); chk(rv, 32'h0000_0004);
      payload <= 24'h00_0040;
      acc <= 18'h2_0000;
      wr(8'h00, 32'h0000_0012);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, nfm}, 32'h1);
      acc <= 18'h0_0000;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, nfm}, 32'h0);
      wr(8'h00, 32'h0000_0011);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, nfm}, 32'h1);
      $display("test net filter done");
      results;
   end
endmodule
